// *** shared/cscr_pkg.sv ***
// Constants for the converter system configuration registers.
// Assumes a 40 MHz core clock and byte-wide command codes from the bus link.
`default_nettype none
package cscr_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam real CLK_MHZ = 40.0;
	localparam real PGD_T1_MS = 0.5;
	localparam real PGD_T2_MS = 1.0;
	localparam real PGD_T3_MS = 2.0;
	localparam int PGD_T1_CYC = int'($ceil(PGD_T1_MS * 1000.0 * CLK_MHZ));
	localparam int PGD_T2_CYC = int'($ceil(PGD_T2_MS * 1000.0 * CLK_MHZ));
	localparam int PGD_T3_CYC = int'($ceil(PGD_T3_MS * 1000.0 * CLK_MHZ));
	localparam int PGD_CNT_W = 17;
	localparam int OFF_CNT_W = 16;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [7:0] CMD_STORE_ALL = 8'h15;
	localparam logic [7:0] REG_MISC_CFG = 8'hA0;
	localparam logic [7:0] REG_SLAVE_ADDR = 8'hA2;
	localparam logic [7:0] REG_VOUT_SETPOINT = 8'hA6;
	localparam logic [7:0] REG_BUS_OFFSET = 8'hA8;

	// ****************************************
	// Field positions of system_misc_config
	// ****************************************
	localparam int BIT_FCCM = 7;
	localparam int BIT_SRC_HI = 6;
	localparam int BIT_SRC_LO = 5;
	localparam int BIT_SOFT_STOP = 4;
	localparam int BIT_PGD_HI = 3;
	localparam int BIT_PGD_LO = 2;
	localparam int BIT_VID_OVRD = 1;
	localparam int BIT_ADDR_SRC = 0;
	localparam logic [1:0] SRC_ALL_VID = 2'h0;
	localparam logic [1:0] SRC_VID_VOUT = 2'h1;

	// ****************************************
	// Reset values and null read data
	// ****************************************
	localparam logic [7:0] NVM_MISC_DEFAULT = 8'h00;
	localparam logic [6:0] NVM_ADDR_DEFAULT = 7'h00;
	localparam logic [7:0] SETPOINT_RST = 8'h00;
	localparam logic [7:0] OFFSET_RST = 8'h00;
	localparam logic [7:0] READ_NULL = 8'h00;

	typedef enum logic [1:0] {OFF_RUN, OFF_WAIT, OFF_RAMP, OFF_STOP} cscr_off_t;
endpackage
`default_nettype wire

// *** src/cscr_link_port.sv ***
// Link-side port: takes byte transactions on the link clock and hands them to the core.
// Assumes the link logic holds no new request while busy is high.
`default_nettype none
module cscr_link_port (
	input wire logic link_clk,
	input wire logic link_rst_b,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] cmd,
	input wire logic [7:0] wdata,
	input wire logic ack_tgl,
	input wire logic rsp_nack,
	input wire logic [7:0] rsp_rdata,
	output logic req_tgl,
	output logic req_wr,
	output logic [7:0] req_cmd,
	output logic [7:0] req_wdata,
	output logic busy,
	output logic done,
	output logic nack,
	output logic [7:0] rdata
);
	import cscr_pkg::*;

	typedef struct packed {
		logic req_tgl;
		logic req_wr;
		logic [7:0] req_cmd;
		logic [7:0] req_wdata;
		logic busy;
		logic done;
		logic nack;
		logic [7:0] rdata;
		logic ack_s1;
		logic ack_s2;
	} cscr_lk_t;

	cscr_lk_t lk_ff, nxt_lk;

	always_comb begin
		nxt_lk = lk_ff;
		nxt_lk.ack_s1 = ack_tgl;
		nxt_lk.ack_s2 = lk_ff.ack_s1;
		nxt_lk.done = 1'b0;
		// Request fields stay frozen while busy so the core may sample them late
		if (lk_ff.busy) begin
			if (lk_ff.ack_s2 == lk_ff.req_tgl) begin
				nxt_lk.busy = 1'b0;
				nxt_lk.done = 1'b1;
				nxt_lk.nack = rsp_nack;
				nxt_lk.rdata = rsp_rdata;
			end
		end else if (wr || rd) begin
			nxt_lk.busy = 1'b1;
			nxt_lk.req_wr = wr;
			nxt_lk.req_cmd = cmd;
			nxt_lk.req_wdata = wdata;
			nxt_lk.req_tgl = ~lk_ff.req_tgl;
		end
		if (!link_rst_b) begin
			nxt_lk = '0;
		end
	end

	always_ff @(posedge link_clk) begin
		lk_ff <= nxt_lk;
	end

	assign req_tgl = lk_ff.req_tgl;
	assign req_wr = lk_ff.req_wr;
	assign req_cmd = lk_ff.req_cmd;
	assign req_wdata = lk_ff.req_wdata;
	assign busy = lk_ff.busy;
	assign done = lk_ff.done;
	assign nack = lk_ff.nack;
	assign rdata = lk_ff.rdata;

	a_link_done_ends: assert property (@(posedge link_clk) disable iff (!link_rst_b)
		lk_ff.done |-> !lk_ff.busy && $past(lk_ff.busy))
		else $error("done without a pending request");
endmodule // cscr_link_port
`default_nettype wire

// *** src/cscr_config_regs.sv ***
// Core of the converter system configuration registers on the core clock.
// Assumes the link port sits on its own clock and power-stage status arrives on the core clock.
`default_nettype none
module cscr_config_regs #(
	parameter int PGD_CYC_1 = cscr_pkg::PGD_T1_CYC,
	parameter int PGD_CYC_2 = cscr_pkg::PGD_T2_CYC,
	parameter int PGD_CYC_3 = cscr_pkg::PGD_T3_CYC
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic POR_B,
	input wire logic LINK_CLK,
	input wire logic LINK_RST_B,
	input wire logic LINK_WR,
	input wire logic LINK_RD,
	input wire logic [7:0] LINK_CMD,
	input wire logic [7:0] LINK_WDATA,
	output logic LINK_DONE,
	output logic LINK_NACK,
	output logic [7:0] LINK_RDATA,
	output logic LINK_BUSY,
	input wire logic [6:0] ADDR_STRAP,
	input wire logic SWITCH_ENABLED,
	input wire logic ONOFF_ALWAYS_ON,
	input wire logic [7:0] SVID_VOUT,
	input wire logic [7:0] SVID_OFFSET,
	input wire logic SOFT_START_DONE,
	input wire logic TURN_OFF_REQ,
	input wire logic [cscr_pkg::OFF_CNT_W-1:0] TURN_OFF_DELAY_CYC,
	input wire logic [cscr_pkg::OFF_CNT_W-1:0] TURN_OFF_RAMP_CYC,
	output logic LIGHT_LOAD_FCCM,
	output logic [7:0] VOUT_SETPOINT,
	output logic [7:0] VOUT_OFFSET,
	output logic SOFT_STOP_EN,
	output logic SOFT_RAMP_ACTIVE,
	output logic SWITCH_STOP,
	output logic POWER_GOOD,
	output logic VID_ADDR_OVERRIDE,
	output logic [6:0] SLAVE_ADDR
);
	import cscr_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] misc_cfg;
		logic [6:0] addr_reg;
		logic [7:0] setpoint;
		logic [7:0] offset;
		logic [7:0] nvm_misc;
		logic [6:0] nvm_addr;
		logic eff_fccm;
		logic [1:0] eff_src;
		logic eff_soft;
		logic [1:0] eff_pgd;
		logic boot_addr_src;
		logic boot_vid_ovrd;
		logic [6:0] boot_addr;
		logic [6:0] strap_s1;
		logic [6:0] strap_s2;
		logic [6:0] strap_addr;
		logic [1:0] strap_cnt;
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic ack_tgl;
		logic rsp_nack;
		logic [7:0] rsp_rdata;
		logic [PGD_CNT_W-1:0] pg_cnt;
		logic pg_out;
		cscr_off_t off_state;
		logic [OFF_CNT_W-1:0] off_cnt;
		logic sw_stop;
		logic ramp_act;
		logic [7:0] vout_out;
		logic [7:0] ofs_out;
		logic [6:0] slave_addr_out;
	} cscr_state_t;

	cscr_state_t st_ff, nxt_st;

	logic lk_req_tgl;
	logic lk_req_wr;
	logic [7:0] lk_req_cmd;
	logic [7:0] lk_req_wdata;
	logic req_new;
	logic apply_ok;

	// Decode used by both the state update and the checks
	function automatic logic [PGD_CNT_W-1:0] pgd_cycles(input logic [1:0] code);
		unique case (code)
			2'h0: pgd_cycles = '0;
			2'h1: pgd_cycles = PGD_CNT_W'(PGD_CYC_1);
			2'h2: pgd_cycles = PGD_CNT_W'(PGD_CYC_2);
			2'h3: pgd_cycles = PGD_CNT_W'(PGD_CYC_3);
		endcase
	endfunction

	// ****************************************
	// Link port
	// ****************************************
	cscr_link_port u_link (
		.link_clk(LINK_CLK),
		.link_rst_b(LINK_RST_B),
		.wr(LINK_WR),
		.rd(LINK_RD),
		.cmd(LINK_CMD),
		.wdata(LINK_WDATA),
		.ack_tgl(st_ff.ack_tgl),
		.rsp_nack(st_ff.rsp_nack),
		.rsp_rdata(st_ff.rsp_rdata),
		.req_tgl(lk_req_tgl),
		.req_wr(lk_req_wr),
		.req_cmd(lk_req_cmd),
		.req_wdata(lk_req_wdata),
		.busy(LINK_BUSY),
		.done(LINK_DONE),
		.nack(LINK_NACK),
		.rdata(LINK_RDATA)
	);

	assign req_new = st_ff.req_s2 != st_ff.req_seen;
	assign apply_ok = !SWITCH_ENABLED && !ONOFF_ALWAYS_ON;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		// Request toggle and strap cross through two flops; the first is read only by the second
		nxt_st.req_s1 = lk_req_tgl;
		nxt_st.req_s2 = st_ff.req_s1;
		nxt_st.strap_s1 = ADDR_STRAP;
		nxt_st.strap_s2 = st_ff.strap_s1;
		if (st_ff.strap_cnt != STRAP_SETTLE) begin
			nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
			nxt_st.strap_addr = st_ff.strap_s2;
		end

		// Mode fields only reach the power stage while it is quiet
		if (apply_ok) begin
			nxt_st.eff_fccm = st_ff.misc_cfg[BIT_FCCM];
			nxt_st.eff_src = st_ff.misc_cfg[BIT_SRC_HI:BIT_SRC_LO];
			nxt_st.eff_soft = st_ff.misc_cfg[BIT_SOFT_STOP];
			nxt_st.eff_pgd = st_ff.misc_cfg[BIT_PGD_HI:BIT_PGD_LO];
		end

		// Command handling; the response is stable before the ack toggle is seen
		if (req_new) begin
			nxt_st.req_seen = st_ff.req_s2;
			nxt_st.ack_tgl = ~st_ff.ack_tgl;
			nxt_st.rsp_nack = 1'b0;
			nxt_st.rsp_rdata = READ_NULL;
			if (lk_req_wr) begin
				unique case (lk_req_cmd)
					REG_MISC_CFG: nxt_st.misc_cfg = lk_req_wdata;
					REG_SLAVE_ADDR: nxt_st.addr_reg = lk_req_wdata[6:0];
					REG_VOUT_SETPOINT: nxt_st.setpoint = lk_req_wdata;
					REG_BUS_OFFSET: begin
						if (st_ff.eff_src == SRC_ALL_VID) begin
							nxt_st.rsp_nack = 1'b1;
						end else begin
							nxt_st.offset = lk_req_wdata;
						end
					end
					CMD_STORE_ALL: begin
						nxt_st.nvm_misc = st_ff.misc_cfg;
						nxt_st.nvm_addr = st_ff.addr_reg;
					end
					default: nxt_st.rsp_nack = 1'b1;
				endcase
			end else begin
				unique case (lk_req_cmd)
					REG_MISC_CFG: nxt_st.rsp_rdata = st_ff.misc_cfg;
					REG_SLAVE_ADDR: begin
						if (st_ff.misc_cfg[BIT_ADDR_SRC]) begin
							nxt_st.rsp_rdata = {1'b0, st_ff.addr_reg};
						end else begin
							nxt_st.rsp_rdata = {1'b0, st_ff.strap_addr};
						end
					end
					REG_VOUT_SETPOINT: nxt_st.rsp_rdata = st_ff.setpoint;
					REG_BUS_OFFSET: nxt_st.rsp_rdata = st_ff.offset;
					default: nxt_st.rsp_nack = 1'b1;
				endcase
			end
		end

		// Voltage and offset source
		unique case (st_ff.eff_src)
			SRC_ALL_VID: begin
				nxt_st.vout_out = SVID_VOUT;
				nxt_st.ofs_out = SVID_OFFSET;
			end
			SRC_VID_VOUT: begin
				nxt_st.vout_out = SVID_VOUT;
				nxt_st.ofs_out = st_ff.offset;
			end
			default: begin
				nxt_st.vout_out = st_ff.setpoint;
				nxt_st.ofs_out = st_ff.offset;
			end
		endcase

		// Slave address as fixed at the last supply reset
		nxt_st.slave_addr_out = st_ff.boot_addr_src ? st_ff.boot_addr : st_ff.strap_addr;

		// Power-good rising delay
		if (!SOFT_START_DONE) begin
			nxt_st.pg_cnt = '0;
			nxt_st.pg_out = 1'b0;
		end else if (st_ff.pg_cnt >= pgd_cycles(st_ff.eff_pgd)) begin
			nxt_st.pg_out = 1'b1;
		end else begin
			nxt_st.pg_cnt = st_ff.pg_cnt + PGD_CNT_W'(1);
		end

		// Turn-off sequence
		unique case (st_ff.off_state)
			OFF_RUN: begin
				nxt_st.off_cnt = '0;
				if (TURN_OFF_REQ) begin
					if (st_ff.eff_soft) begin
						nxt_st.off_state = OFF_WAIT;
					end else begin
						nxt_st.off_state = OFF_STOP;
						nxt_st.sw_stop = 1'b1;
					end
				end
			end
			OFF_WAIT: begin
				if (st_ff.off_cnt >= TURN_OFF_DELAY_CYC) begin
					nxt_st.off_state = OFF_RAMP;
					nxt_st.off_cnt = '0;
					nxt_st.ramp_act = 1'b1;
				end else begin
					nxt_st.off_cnt = st_ff.off_cnt + OFF_CNT_W'(1);
				end
			end
			OFF_RAMP: begin
				if (st_ff.off_cnt >= TURN_OFF_RAMP_CYC) begin
					nxt_st.off_state = OFF_STOP;
					nxt_st.ramp_act = 1'b0;
					nxt_st.sw_stop = 1'b1;
				end else begin
					nxt_st.off_cnt = st_ff.off_cnt + OFF_CNT_W'(1);
				end
			end
			OFF_STOP: begin
				if (!TURN_OFF_REQ) begin
					nxt_st.off_state = OFF_RUN;
					nxt_st.sw_stop = 1'b0;
				end
			end
		endcase

		// Supply reset reloads from the stored image; power-on also clears the image
		if (!RST_B || !POR_B) begin
			nxt_st = '0;
			nxt_st.off_state = OFF_RUN;
			nxt_st.setpoint = SETPOINT_RST;
			nxt_st.offset = OFFSET_RST;
			nxt_st.nvm_misc = POR_B ? st_ff.nvm_misc : NVM_MISC_DEFAULT;
			nxt_st.nvm_addr = POR_B ? st_ff.nvm_addr : NVM_ADDR_DEFAULT;
			nxt_st.misc_cfg = nxt_st.nvm_misc;
			nxt_st.addr_reg = nxt_st.nvm_addr;
			nxt_st.eff_fccm = nxt_st.nvm_misc[BIT_FCCM];
			nxt_st.eff_src = nxt_st.nvm_misc[BIT_SRC_HI:BIT_SRC_LO];
			nxt_st.eff_soft = nxt_st.nvm_misc[BIT_SOFT_STOP];
			nxt_st.eff_pgd = nxt_st.nvm_misc[BIT_PGD_HI:BIT_PGD_LO];
			nxt_st.boot_addr_src = nxt_st.nvm_misc[BIT_ADDR_SRC];
			nxt_st.boot_vid_ovrd = nxt_st.nvm_misc[BIT_VID_OVRD];
			nxt_st.boot_addr = nxt_st.nvm_addr;
			// Handshake stays in step with the link side, so a stale request is not replayed after reset
			nxt_st.req_s1 = lk_req_tgl;
			nxt_st.req_s2 = st_ff.req_s1;
			nxt_st.req_seen = st_ff.req_s2;
			nxt_st.ack_tgl = st_ff.req_s2;
			nxt_st.rsp_nack = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		st_ff <= nxt_st;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign LIGHT_LOAD_FCCM = st_ff.eff_fccm;
	assign VOUT_SETPOINT = st_ff.vout_out;
	assign VOUT_OFFSET = st_ff.ofs_out;
	assign SOFT_STOP_EN = st_ff.eff_soft;
	assign SOFT_RAMP_ACTIVE = st_ff.ramp_act;
	assign SWITCH_STOP = st_ff.sw_stop;
	assign POWER_GOOD = st_ff.pg_out;
	assign VID_ADDR_OVERRIDE = st_ff.boot_vid_ovrd;
	assign SLAVE_ADDR = st_ff.slave_addr_out;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B || !POR_B);

	a_fccm_applied: assert property (apply_ok ##1 apply_ok |=> LIGHT_LOAD_FCCM == $past(st_ff.misc_cfg[BIT_FCCM]))
		else $error("conduction mode not applied");
	a_offset_nack: assert property (req_new && lk_req_wr && lk_req_cmd == REG_BUS_OFFSET
		&& st_ff.eff_src == SRC_ALL_VID |=> st_ff.rsp_nack && $stable(st_ff.offset))
		else $error("offset write not refused");
	a_offset_kept: assert property ($past(st_ff.rsp_nack) == 1'b0 && st_ff.rsp_nack && $stable(st_ff.ack_tgl) == 1'b0
		&& st_ff.eff_src == SRC_ALL_VID |-> st_ff.offset == $past(st_ff.offset))
		else $error("refused offset write changed the register");
	a_offset_source: assert property (st_ff.eff_src == SRC_VID_VOUT |=> VOUT_OFFSET == $past(st_ff.offset)
		&& VOUT_SETPOINT == $past(SVID_VOUT))
		else $error("offset not from bus register");
	a_vout_source: assert property (st_ff.eff_src[1] |=> VOUT_SETPOINT == $past(st_ff.setpoint))
		else $error("setpoint not from bus register");
	a_stop_now: assert property (st_ff.off_state == OFF_RUN && TURN_OFF_REQ && !st_ff.eff_soft
		|=> SWITCH_STOP && !SOFT_RAMP_ACTIVE)
		else $error("hard stop delayed");
	a_soft_order: assert property (st_ff.off_state == OFF_RUN && TURN_OFF_REQ && st_ff.eff_soft
		|=> !SWITCH_STOP ##1 !SWITCH_STOP)
		else $error("soft stop skipped delay or ramp");
	a_stop_after_ramp: assert property ($rose(SWITCH_STOP) && SOFT_STOP_EN |-> $past(SOFT_RAMP_ACTIVE))
		else $error("switching stopped without ramp");
	a_pg_delay: assert property ($rose(POWER_GOOD) |-> $past(st_ff.pg_cnt) >= pgd_cycles($past(st_ff.eff_pgd)))
		else $error("power good rose early");
	a_pg_drop: assert property (!SOFT_START_DONE |=> !POWER_GOOD)
		else $error("power good without soft start");
	a_ovrd_store: assert property (req_new && lk_req_wr && lk_req_cmd == REG_MISC_CFG
		|=> st_ff.misc_cfg[BIT_VID_OVRD] == $past(lk_req_wdata[BIT_VID_OVRD]) && $stable(VID_ADDR_OVERRIDE))
		else $error("override bit mishandled");
	a_hold_modes: assert property (!apply_ok |=> $stable(st_ff.eff_src) && $stable(SOFT_STOP_EN))
		else $error("mode applied while switching");
	a_addr_source: assert property (st_ff.strap_cnt == STRAP_SETTLE && $past(st_ff.strap_cnt) == STRAP_SETTLE
		|=> SLAVE_ADDR ==
		($past(st_ff.boot_addr_src) ? $past(st_ff.boot_addr) : $past(st_ff.strap_addr)) && $stable(SLAVE_ADDR))
		else $error("slave address wrong or moved");
	a_addr_readback: assert property (req_new && !lk_req_wr && lk_req_cmd == REG_SLAVE_ADDR
		&& !st_ff.misc_cfg[BIT_ADDR_SRC] |=> st_ff.rsp_rdata == {1'b0, $past(st_ff.strap_addr)})
		else $error("address readback wrong");
endmodule // cscr_config_regs
`default_nettype wire

// *** dv/cscr_link_host.sv ***
// Link host model: issues single-byte write and read transfers on the link clock.
// Assumes the bench calls xfer only after both resets are released.
`default_nettype none
module cscr_link_host (
	input wire logic LINK_CLK,
	input wire logic LINK_DONE,
	input wire logic LINK_NACK,
	input wire logic [7:0] LINK_RDATA,
	input wire logic LINK_BUSY,
	output logic LINK_WR,
	output logic LINK_RD,
	output logic [7:0] LINK_CMD,
	output logic [7:0] LINK_WDATA
);
	timeunit 1ns;
	timeprecision 1ps;
	// ******
	// Idle state
	// ******
	initial begin
		LINK_WR = 1'b0;
		LINK_RD = 1'b0;
		LINK_CMD = 8'hA5;
		LINK_WDATA = 8'h5A;
	end
	// ******
	// One transfer
	// ******
	// Single byte per transfer, one at a time
	task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [7:0] wd,
		output logic nk, output logic [7:0] rd, output logic ok);
		int n;
		ok = 1'b0;
		nk = 1'b1;
		rd = 8'hFF;
		@(negedge LINK_CLK);
		for (n = 0; n < 64 && LINK_BUSY !== 1'b0; n++) begin
			@(negedge LINK_CLK);
		end
		LINK_WR = wr;
		LINK_RD = !wr;
		LINK_CMD = cmd;
		LINK_WDATA = wd;
		@(negedge LINK_CLK);
		LINK_WR = 1'b0;
		LINK_RD = 1'b0;
		// Released lines flip so a stale value never looks valid
		LINK_CMD = ~cmd;
		LINK_WDATA = ~wd;
		for (n = 0; n < 64 && !ok; n++) begin
			@(posedge LINK_CLK);
			#1;
			if (LINK_DONE === 1'b1) begin
				ok = 1'b1;
				nk = LINK_NACK;
				rd = LINK_RDATA;
			end
		end
	endtask
endmodule // cscr_link_host
`default_nettype wire

// *** dv/cscr_config_regs_tb.sv ***
// Self-checking bench for the configuration register core, driven through the link host model.
// Assumes a 25 ns core clock, a 15 ns link clock and short power-good counts.
`default_nettype none
module cscr_config_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cscr_pkg::*;
	logic clk, link_clk, rst_b, por_b, link_rst_b, link_wr, link_rd, link_done, link_nack, link_busy;
	logic sw_en, aon, ssd, off_req, fccm, soft_en, ramp, stop, pg, vid_ovr, nk;
	logic [7:0] link_cmd, link_wdata, link_rdata, svid_vout, svid_off, vsp, voff, rb, misc, sp, ofs, na;
	logic [6:0] strap, slave_addr;
	logic [15:0] off_dly, off_ramp;
	integer seed, err_count, samples_checked;
	int n, t_ramp, n_ramp, t_stop;
	localparam int PGD [4] = '{0, 5, 10, 20};
	// ******
	// Design and link host
	// ******
	cscr_config_regs #(.PGD_CYC_1(5), .PGD_CYC_2(10), .PGD_CYC_3(20)) DUT (.CLK(clk), .RST_B(rst_b),
		.POR_B(por_b), .LINK_CLK(link_clk), .LINK_RST_B(link_rst_b), .LINK_WR(link_wr), .LINK_RD(link_rd),
		.LINK_CMD(link_cmd), .LINK_WDATA(link_wdata), .LINK_DONE(link_done), .LINK_NACK(link_nack),
		.LINK_RDATA(link_rdata), .LINK_BUSY(link_busy), .ADDR_STRAP(strap), .SWITCH_ENABLED(sw_en),
		.ONOFF_ALWAYS_ON(aon), .SVID_VOUT(svid_vout), .SVID_OFFSET(svid_off), .SOFT_START_DONE(ssd),
		.TURN_OFF_REQ(off_req), .TURN_OFF_DELAY_CYC(off_dly), .TURN_OFF_RAMP_CYC(off_ramp),
		.LIGHT_LOAD_FCCM(fccm), .VOUT_SETPOINT(vsp), .VOUT_OFFSET(voff), .SOFT_STOP_EN(soft_en),
		.SOFT_RAMP_ACTIVE(ramp), .SWITCH_STOP(stop), .POWER_GOOD(pg), .VID_ADDR_OVERRIDE(vid_ovr),
		.SLAVE_ADDR(slave_addr));
	cscr_link_host host (.LINK_CLK(link_clk), .LINK_DONE(link_done), .LINK_NACK(link_nack),
		.LINK_RDATA(link_rdata), .LINK_BUSY(link_busy), .LINK_WR(link_wr), .LINK_RD(link_rd),
		.LINK_CMD(link_cmd), .LINK_WDATA(link_wdata));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Odd start offset keeps the link clock out of step with the core clock
	initial begin
		link_clk = 1'b0;
		#3.1;
		forever #7.5 link_clk = ~link_clk;
	end
	// ******
	// Helpers
	// ******
	task automatic final_report();
		$display("Compared %0d, mismatched %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [7:0] wd, input logic exp_nk);
		logic ok;
		host.xfer(wr, cmd, wd, nk, rb, ok);
		if (!ok) begin
			err_count++;
			final_report();
		end
		chk_bit(nk, exp_nk);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic core_reset();
		@(negedge clk);
		rst_b = 1'b0;
		cyc(3);
		rst_b = 1'b1;
		cyc(6);
	endtask
	// ******
	// Main sequence
	// ******
	initial begin
		seed = 32'hD54D45D1;
		err_count = 0;
		samples_checked = 0;
		rst_b = 1'b0;
		por_b = 1'b0;
		link_rst_b = 1'b0;
		sw_en = 1'b1;
		aon = 1'b0;
		ssd = 1'b0;
		off_req = 1'b0;
		strap = 7'($random(seed));
		svid_vout = 8'($random(seed));
		svid_off = 8'($random(seed));
		off_dly = 16'h0004;
		off_ramp = 16'h0003;
		ofs = OFFSET_RST;
		cyc(10);
		rst_b = 1'b1;
		por_b = 1'b1;
		@(negedge link_clk);
		link_rst_b = 1'b1;
		cyc(6);
		xfer(0, REG_MISC_CFG, 8'h00, 0);
		chk_byte(rb, NVM_MISC_DEFAULT);
		xfer(0, REG_SLAVE_ADDR, 8'h00, 0);
		chk_byte(rb, {1'b0, strap});
		chk_byte({1'b0, slave_addr}, {1'b0, strap});
		// Every source select code, with apply gating on each
		for (int s = 0; s < 4; s++) begin
			sw_en = 1'b1;
			misc = 8'($random(seed));
			misc[6:5] = 2'(s);
			misc[7] = ~fccm;
			misc[4] = ~soft_en;
			xfer(1, REG_MISC_CFG, misc, 0);
			cyc(3);
			chk_bit(fccm, ~misc[7]);
			aon = 1'b1;
			sw_en = 1'b0;
			cyc(3);
			chk_bit(soft_en, ~misc[4]);
			aon = 1'b0;
			cyc(3);
			chk_bit(fccm, misc[7]);
			chk_bit(soft_en, misc[4]);
			xfer(0, REG_MISC_CFG, 8'h00, 0);
			chk_byte(rb, misc);
			sp = 8'($random(seed));
			na = 8'($random(seed));
			xfer(1, REG_VOUT_SETPOINT, sp, 0);
			xfer(1, REG_BUS_OFFSET, na, s == 0);
			if (s != 0) begin
				ofs = na;
			end
			xfer(0, REG_BUS_OFFSET, 8'h00, 0);
			chk_byte(rb, ofs);
			@(negedge clk);
			svid_vout = 8'($random(seed));
			svid_off = 8'($random(seed));
			cyc(3);
			chk_byte(vsp, (s >= 2) ? sp : svid_vout);
			chk_byte(voff, (s == 0) ? svid_off : ofs);
		end
		// Power-good delay for every code
		for (int c = 0; c < 4; c++) begin
			misc[3:2] = 2'(c);
			xfer(1, REG_MISC_CFG, misc, 0);
			cyc(3);
			ssd = 1'b1;
			for (n = 0; n < 100 && pg !== 1'b1; n++) begin
				@(posedge clk);
				#1;
			end
			chk_byte(8'(n), 8'(PGD[c] + 1));
			@(negedge clk);
			ssd = 1'b0;
			cyc(2);
			chk_bit(pg, 1'b0);
		end
		// Turn-off without and with soft stop
		for (int k = 0; k < 2; k++) begin
			misc[4] = k[0];
			xfer(1, REG_MISC_CFG, misc, 0);
			off_dly = 16'($unsigned($random(seed)) % 8 + 2);
			off_ramp = 16'($unsigned($random(seed)) % 8 + 2);
			cyc(3);
			off_req = 1'b1;
			t_ramp = 0;
			n_ramp = 0;
			t_stop = 0;
			for (n = 1; n <= 200 && t_stop == 0; n++) begin
				@(posedge clk);
				#1;
				if (ramp === 1'b1 && t_ramp == 0) begin
					t_ramp = n;
				end
				if (ramp === 1'b1) begin
					n_ramp++;
				end
				if (stop === 1'b1) begin
					t_stop = n;
				end
			end
			chk_bit(t_stop == 1, k == 0);
			chk_byte(8'(n_ramp), k ? 8'(off_ramp + 1) : 8'h00);
			chk_bit(t_ramp > off_dly, k == 1);
			if (t_stop == 0) begin
				final_report();
			end
			@(negedge clk);
			off_req = 1'b0;
			cyc(2);
			chk_bit(stop, 1'b0);
		end
		xfer(0, 8'h3C, 8'h00, 1);
		chk_byte(rb, READ_NULL);
		// Address change needs store-all and a supply reset
		na = 8'($random(seed)) | 8'h80;
		misc[1:0] = 2'h3;
		xfer(1, REG_SLAVE_ADDR, na, 0);
		xfer(1, REG_MISC_CFG, misc, 0);
		core_reset();
		chk_byte({1'b0, slave_addr}, {1'b0, strap});
		chk_bit(vid_ovr, 1'b0);
		xfer(1, REG_SLAVE_ADDR, na, 0);
		xfer(1, REG_MISC_CFG, misc, 0);
		xfer(1, CMD_STORE_ALL, 8'($random(seed)), 0);
		core_reset();
		chk_byte({1'b0, slave_addr}, {1'b0, na[6:0]});
		chk_bit(vid_ovr, 1'b1);
		xfer(0, REG_SLAVE_ADDR, 8'h00, 0);
		chk_byte(rb, {1'b0, na[6:0]});
		xfer(0, REG_MISC_CFG, 8'h00, 0);
		chk_byte(rb, misc);
		final_report();
	end
endmodule // cscr_config_regs_tb
`default_nettype wire
